// ### hdl/frame_pkg.sv
package frame_pkg;
  // frame layout
  localparam int ADDR_LSB      = 0;
  localparam int ADDR_W        = 7;
  localparam int OP_BIT        = 7;
  localparam int DATA_LSB      = 8;
  localparam int FRAME_BITS    = 16;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] ADDR_DONE = 5'h06;
  // address map
  localparam logic [6:0] CTRL_LAST      = 7'h1E;
  localparam logic [6:0] STAT_FIRST     = 7'h40;
  localparam logic [6:0] STAT_LAST      = 7'h7E;
  localparam logic [6:0] MODE_CTRL      = 7'h01;
  localparam logic [6:0] CAN_CTRL       = 7'h04;
  localparam logic [6:0] HS_CTRL_A      = 7'h14;
  localparam logic [6:0] HS_CTRL_B      = 7'h15;
  localparam logic [6:0] SUPPLY_B_STAT  = 7'h40;
  localparam logic [6:0] SUPPLY_A_STAT  = 7'h41;
  localparam logic [6:0] THERMAL_STAT   = 7'h42;
  localparam logic [6:0] DEV_STATE_STAT = 7'h43;
  localparam logic [6:0] BUS_FAULT_STAT = 7'h44;
  localparam logic [6:0] WAKE_SRC_A     = 7'h46;
  localparam logic [6:0] WAKE_SRC_B     = 7'h47;
  localparam logic [6:0] WAKE_LEVEL     = 7'h48;
  localparam logic [6:0] SW_OVERLOAD    = 7'h54;
  localparam logic [6:0] SW_OPEN_LOAD   = 7'h55;
  localparam logic [6:0] FAMILY_ID      = 7'h7E;
  // fields inside control bytes
  localparam int MODE_LSB      = 6;
  localparam int AUX_EN_BIT    = 3;
  localparam int CAN_LSB       = 0;
  localparam logic [2:0] CAN_OFF      = 3'h0;
  localparam logic [2:0] CAN_WAKE_CAP = 3'h1;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  // arbitrary neutral identifier value
  localparam logic [7:0] FAMILY_ID_VAL = 8'h5A;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART
  } chip_mode_t;
endpackage

// ### hdl/spi_register_access_frame.sv
// Notes on behaviour
// (R1) frame bits 6..0 give the register address
// (R2) bit 7 picks read or read-and-clear, read or write
// (R3) bits 15..8 carry the data byte both ways
// (R4) every access acts on a whole byte
// (R5) status bits stay set until the host clears them
// (R6) frames are not interpreted in restart mode
// (R7) status register contents return in the same frame
// (R8) control reads show the value from before the frame
// (R9) every response carries the eight-bit status summary
// (R10) summary bit drops only when its whole register is clear
// (R11) summary bits 0..3 map supply, thermal, device, bus status
// (R12) summary bit 4 ORs both wake source registers
// (R13) summary bits 5..7 map second supply, overload, open load
// (R14) wake pin level register never touches the summary
// (R15) control space 0x00..0x1E, bit 7 high writes
// (R16) status space 0x40..0x7E, bit 7 high clears after report
// (R17) wake level and family identifier ignore clears
// (R18) drivers may be enabled while failure flags stay set
// (R19) mode change updates the mode bits to the entered mode
// (R20) low-power entry keeps diagnosis, fail output stays active
// (R21) stop keeps CAN bits; sleep changes them unless off or wake
// (R22) switches stay on, configurable only in normal, fault turns off
// (R23) restart clears switch and aux regulator config bits
// (R24) chip select low, sample on clock fall, shift on rise
// (R25) count not 0 or 16 discards frame, flags error next
// (R26) summary captured at chip select fall, stable while shifting
`timescale 1ns/1ps
`default_nettype none
module spi_register_access_frame
  import frame_pkg::*;
#(
  parameter int N_SWITCH = 4
)(
  // clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                reset_i,
  input  wire logic                ce_i,
  // serial port
  input  wire logic                chip_select_low_i,
  input  wire logic                sclk_i,
  input  wire logic                sdi_i,
  output logic                     sdo_o,
  output logic                     sdo_oe_o,
  // chip state
  input  wire logic                mode_change_i,
  input  wire chip_mode_t          mode_entered_i,
  input  wire logic                status_set_i,
  input  wire logic [6:0]          status_set_addr_i,
  input  wire logic [7:0]          status_set_bits_i,
  input  wire logic [7:0]          wake_level_i,
  input  wire logic [N_SWITCH-1:0] switch_fault_i,
  input  wire logic                fail_trigger_i,
  // controlled functions
  output logic [N_SWITCH-1:0]      high_side_switch_o,
  output logic                     aux_regulator_o,
  output logic [2:0]               can_mode_o,
  output logic                     fail_output_o,
  output logic [7:0]               status_summary_o
);

  logic [7:0]  ctrl_q [0:30];
  logic [7:0]  stat_q [0:63];
  chip_mode_t  mode_q;
  logic        cs_q;
  logic        sclk_q;
  logic [15:0] rx_q;
  logic [4:0]  cnt_q;
  logic        err_q;
  logic        abort_q;
  logic        load_q;
  logic [7:0]  tx_data_q;
  logic [7:0]  summary_q;

  function automatic logic nz(input logic [7:0] b);
    return |b;
  endfunction

  // edges of the serial pins, all sampled on sys_clk
  wire cs_fall   = cs_q & ~chip_select_low_i;
  wire cs_rise   = ~cs_q & chip_select_low_i;
  wire sclk_fall = ~cs_q & sclk_q & ~sclk_i;
  wire sclk_rise = ~cs_q & ~sclk_q & sclk_i;
  wire restart   = (mode_q == MODE_RESTART);

  // decoded frame
  wire [6:0] f_addr = rx_q[ADDR_LSB +: ADDR_W]; // R1
  wire       f_op   = rx_q[OP_BIT]; // R2
  wire [7:0] f_data = rx_q[DATA_LSB +: 8]; // R3 R4
  wire       f_ctrl = (f_addr <= CTRL_LAST); // R15
  wire       f_stat = (f_addr >= STAT_FIRST) && (f_addr <= STAT_LAST); // R16
  wire       f_good = cs_rise && (cnt_q == FRAME_LEN) && !abort_q
                      && !restart; // R6 R25
  wire       hs_reg = (f_addr == HS_CTRL_A) || (f_addr == HS_CTRL_B);
  wire       do_wr  = f_good && f_ctrl && f_op
                      && !(hs_reg && mode_q != MODE_NORMAL); // R22
  wire       do_clr = f_good && f_stat && f_op
                      && f_addr != WAKE_LEVEL && f_addr != FAMILY_ID; // R17
  wire       bad_len = cs_rise && cnt_q != 5'h00 && cnt_q != FRAME_LEN;

  // address of the response byte, complete after seven clock falls
  wire [6:0] rd_addr = rx_q[15:9];
  wire [7:0] rd_byte =
      (rd_addr == WAKE_LEVEL) ? wake_level_i :
      (rd_addr == FAMILY_ID)  ? FAMILY_ID_VAL :
      (rd_addr >= STAT_FIRST) ? stat_q[rd_addr[5:0]] : // R7
      (rd_addr <= CTRL_LAST)  ? ctrl_q[rd_addr[4:0]] : // R8
      BYTE_RESET;

  // summary of the status registers; wake level has no bit
  wire [7:0] summary_now = { // R14
    nz(stat_q[SW_OPEN_LOAD[5:0]]),
    nz(stat_q[SW_OVERLOAD[5:0]]),
    nz(stat_q[SUPPLY_B_STAT[5:0]]), // R13
    nz(stat_q[WAKE_SRC_A[5:0]]) | nz(stat_q[WAKE_SRC_B[5:0]]), // R12
    nz(stat_q[BUS_FAULT_STAT[5:0]]),
    nz(stat_q[DEV_STATE_STAT[5:0]]),
    nz(stat_q[THERMAL_STAT[5:0]]),
    nz(stat_q[SUPPLY_A_STAT[5:0]]) // R9 R10 R11
  };

  // response bit shifted out after each rising clock edge
  wire [3:0] tx_idx = cnt_q[3:0];
  wire       tx_bit = cnt_q[3] ? tx_data_q[tx_idx[2:0]]
                               : summary_q[tx_idx[2:0]];

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cs_q   <= 1'b1;
      sclk_q <= 1'b0;
    end
    else if (ce_i)
    begin
      cs_q   <= chip_select_low_i;
      sclk_q <= sclk_i;
    end
  end

  // frame reception and error tracking
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rx_q    <= 16'h0000;
      cnt_q   <= 5'h00;
      err_q   <= 1'b0;
      abort_q <= 1'b0;
      load_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      load_q <= sclk_fall && (cnt_q == ADDR_DONE);
      if (cs_fall)
      begin
        cnt_q   <= 5'h00;
        abort_q <= sclk_i | restart;
      end
      else if (sclk_fall)
      begin
        rx_q <= {sdi_i, rx_q[15:1]}; // R24
        if (cnt_q != 5'h1F)
          cnt_q <= cnt_q + 5'h01;
      end
      if (!cs_q && restart)
        abort_q <= 1'b1;
      if (cs_rise)
        err_q <= bad_len | abort_q | sclk_i; // R25
    end
  end

  // response side; first level shown is the error flag
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sdo_o     <= 1'b0;
      sdo_oe_o  <= 1'b0;
      summary_q <= 8'h00;
      tx_data_q <= 8'h00;
    end
    else if (ce_i)
    begin
      if (cs_fall)
      begin
        summary_q <= summary_now; // R26
        sdo_o     <= err_q;
        sdo_oe_o  <= 1'b1;
      end
      else if (cs_rise)
        sdo_oe_o <= 1'b0;
      else if (sclk_rise)
        sdo_o <= tx_bit; // R24
      if (load_q)
        tx_data_q <= rd_byte; // R7 R8
    end
  end

  // status bytes: a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < 64; i++)
        stat_q[i] <= BYTE_RESET;
    end
    else if (ce_i)
    begin
      for (int i = 0; i < 64; i++)
      begin
        if (do_clr && f_addr[5:0] == i[5:0])
          stat_q[i] <= BYTE_RESET; // R4 R5 R16
        if (status_set_i && status_set_addr_i[6] &&
            status_set_addr_i[5:0] == i[5:0])
          stat_q[i] <= (do_clr && f_addr[5:0] == i[5:0])
                       ? status_set_bits_i
                       : stat_q[i] | status_set_bits_i; // R5
      end
    end
  end

  // control bytes, host writes then mode side effects
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < 31; i++)
        ctrl_q[i] <= BYTE_RESET;
      mode_q <= MODE_NORMAL;
    end
    else if (ce_i)
    begin
      if (do_wr)
        ctrl_q[f_addr[4:0]] <= f_data; // R4 R15
      // a fault drops the switch without raising a wake
      for (int i = 0; i < N_SWITCH; i++)
        if (switch_fault_i[i])
          ctrl_q[HS_CTRL_A[4:0]][i] <= 1'b0; // R22
      if (mode_change_i)
      begin
        mode_q <= mode_entered_i;
        ctrl_q[MODE_CTRL[4:0]][MODE_LSB +: 2] <= mode_entered_i; // R19
        if (mode_entered_i == MODE_SLEEP &&
            ctrl_q[CAN_CTRL[4:0]][CAN_LSB +: 3] != CAN_OFF &&
            ctrl_q[CAN_CTRL[4:0]][CAN_LSB +: 3] != CAN_WAKE_CAP)
          ctrl_q[CAN_CTRL[4:0]][CAN_LSB +: 3] <= CAN_WAKE_CAP; // R21
        if (mode_entered_i == MODE_RESTART)
        begin
          ctrl_q[HS_CTRL_A[4:0]] <= BYTE_RESET; // R23
          ctrl_q[HS_CTRL_B[4:0]] <= BYTE_RESET;
          ctrl_q[MODE_CTRL[4:0]][AUX_EN_BIT] <= 1'b0;
        end
      end
    end
  end

  // driven outputs; failure flags do not gate the switches
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      high_side_switch_o <= '0;
      aux_regulator_o    <= 1'b0;
      can_mode_o         <= CAN_OFF;
      fail_output_o      <= 1'b0;
      status_summary_o   <= 8'h00;
    end
    else if (ce_i)
    begin
      high_side_switch_o <= ctrl_q[HS_CTRL_A[4:0]][N_SWITCH-1:0]; // R18 R22
      aux_regulator_o    <= ctrl_q[MODE_CTRL[4:0]][AUX_EN_BIT];
      can_mode_o         <= ctrl_q[CAN_CTRL[4:0]][CAN_LSB +: 3];
      // only reset releases it; no mode change does
      if (fail_trigger_i)
        fail_output_o <= 1'b1; // R20 R23
      status_summary_o <= summary_q;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_bad_end;
    ce_i && bad_len;
  endsequence

  sequence s_frame_open;
    ce_i && cs_fall;
  endsequence

  a_err_next_frame: assert property (s_bad_end |=> err_q) // R25
    else $error("bad clock count not flagged");
  a_err_shown_first: assert property (
      s_frame_open |=> sdo_oe_o && sdo_o == $past(err_q)) // R25
    else $error("error flag not shown at frame start");
  a_summary_held: assert property (
      !cs_q && !cs_fall && !cs_rise |=> $stable(summary_q)) // R26
    else $error("summary moved during frame");
  a_no_restart_write: assert property (
      ce_i && restart && cs_rise |=> !$past(do_wr) && !$past(do_clr)) // R6
    else $error("frame acted on in restart mode");
  a_status_sticky: assert property (
      ce_i && nz(stat_q[THERMAL_STAT[5:0]]) && !do_clr
      |=> nz(stat_q[THERMAL_STAT[5:0]])) // R5
    else $error("status byte cleared on its own");
  a_wake_or_bit: assert property (
      ce_i && cs_fall && nz(stat_q[WAKE_SRC_B[5:0]])
      |=> summary_q[4]) // R12
    else $error("wake summary bit wrong");
  a_mode_bits: assert property (
      ce_i && mode_change_i |=> ctrl_q[MODE_CTRL[4:0]][MODE_LSB +: 2]
                                == $past(mode_entered_i)) // R19
    else $error("mode bits not updated");
  a_restart_clear: assert property (
      ce_i && mode_change_i && mode_entered_i == MODE_RESTART
      |=> ctrl_q[HS_CTRL_A[4:0]] == 8'h00 ##1 high_side_switch_o == '0) // R23
    else $error("switch config survived restart");
  a_fail_kept: assert property (
      fail_output_o |=> fail_output_o) // R20
    else $error("fail output released");
  a_level_no_clear: assert property (
      ce_i && cs_rise && f_addr == WAKE_LEVEL |-> !do_clr) // R17
    else $error("wake level register cleared");
  a_oe_release: assert property (
      ce_i && cs_rise |=> !sdo_oe_o) // R24
    else $error("serial output still driven after frame");
  // a fault or a mode change may still move the byte, so leave them out
  a_switch_locked: assert property (
      ce_i && f_good && f_op && f_addr == HS_CTRL_A && mode_q != MODE_NORMAL
      && !mode_change_i && switch_fault_i == '0
      |=> $stable(ctrl_q[HS_CTRL_A[4:0]])) // R22
    else $error("switch setting written outside normal mode");
  a_can_stop_kept: assert property (
      ce_i && mode_change_i && mode_entered_i == MODE_STOP && !do_wr
      |=> $stable(ctrl_q[CAN_CTRL[4:0]])) // R21
    else $error("CAN bits moved on stop entry");
  a_fail_set: assert property (
      ce_i && fail_trigger_i |=> fail_output_o) // R20
    else $error("fail output not raised");

endmodule
`default_nettype wire

// ### test/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // clock
  input  wire logic sys_clk_i,
  // serial port
  output var  logic chip_select_low_o,
  output var  logic sclk_o,
  output var  logic sdi_o,
  input  wire logic sdo_i
);
  initial
  begin
    chip_select_low_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // 4 cycles a level, four times what the port must resolve
  task automatic hold();
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask
  // lsb first both ways; n other than 0 or 16 makes a bad frame
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [15:0] rx, output logic err);
    rx = 16'h0000;
    @(posedge sys_clk_i);
    #1;
    chip_select_low_o = 1'b0;
    hold();
    err = sdo_i;
    for (int i = 0; i < n; i++)
    begin
      sdi_o = tx[i[3:0]];
      sclk_o = 1'b1;
      hold();
      rx[i[3:0]] = sdo_i;
      sclk_o = 1'b0;
      hold();
    end
    chip_select_low_o = 1'b1;
    sdi_o = ~sdi_o;
    hold();
  endtask
endmodule
`default_nettype wire

// ### test/spi_register_access_frame_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module spi_register_access_frame_tb_top import frame_pkg::*;;
  logic clk, rst, cs_n, sclk, sdi, sdo, sdo_oe, mchg, sset, ftrig, aux;
  logic fail_out, err;
  chip_mode_t mode;
  logic [6:0] saddr;
  logic [7:0] sbits, wlvl, summary;
  logic [3:0] sfault, hs;
  logic [2:0] can;
  logic [15:0] rx;
  int fails, comparisons, cycles;
  logic [6:0] stat_addr [9] = '{SUPPLY_A_STAT, THERMAL_STAT,
    DEV_STATE_STAT, BUS_FAULT_STAT, WAKE_SRC_A, WAKE_SRC_B,
    SUPPLY_B_STAT, SW_OVERLOAD, SW_OPEN_LOAD};
  int stat_bit [9] = '{0, 1, 2, 3, 4, 4, 5, 6, 7};

  spi_register_access_frame #(.N_SWITCH(4)) u_spi_register_access_frame (
    .sys_clk_i(clk), .reset_i(rst), .ce_i(1'b1),
    .chip_select_low_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .mode_change_i(mchg), .mode_entered_i(mode),
    .status_set_i(sset), .status_set_addr_i(saddr),
    .status_set_bits_i(sbits), .wake_level_i(wlvl),
    .switch_fault_i(sfault), .fail_trigger_i(ftrig),
    .high_side_switch_o(hs), .aux_regulator_o(aux),
    .can_mode_o(can), .fail_output_o(fail_out),
    .status_summary_o(summary));

  spi_host_model u_spi_host_model (.sys_clk_i(clk),
    .chip_select_low_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // a hang past this many cycles ends the run as a failure
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic frame(input logic op, input logic [6:0] a,
                       input logic [7:0] d, input int n);
    u_spi_host_model.xfer({d, op, a}, n, rx, err);
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic go_mode(input chip_mode_t m);
    tick();
    mode = m;
    mchg = 1'b1;
    tick();
    mchg = 1'b0;
    repeat (3) tick();
  endtask

  initial
  begin
    rst = 1'b1; mchg = 1'b0; mode = MODE_NORMAL; sset = 1'b0;
    saddr = 7'h00; sbits = 8'h00; wlvl = 8'h3C; sfault = 4'h0;
    ftrig = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (2) tick();
    // each status register with a summary bit: set, read, read-and-clear, read again
    for (int k = 0; k < 9; k++)
    begin
      tick();
      saddr = stat_addr[k]; sbits = 8'hA5; sset = 1'b1;
      tick();
      sset = 1'b0;
      frame(1'b0, stat_addr[k], 8'h00, 16);
      chk(rx, {8'hA5, 8'h01 << stat_bit[k]});
      chk({8'h00, summary}, {8'h00, 8'h01 << stat_bit[k]});
      frame(1'b1, stat_addr[k], 8'h00, 16);
      chk(rx, {8'hA5, 8'h01 << stat_bit[k]});
      frame(1'b0, stat_addr[k], 8'h00, 16);
      chk(rx, 16'h0000);
    end
    frame(1'b1, WAKE_LEVEL, 8'h00, 16);
    chk(rx, 16'h3C00);
    frame(1'b1, FAMILY_ID, 8'h00, 16);
    fork
      frame(1'b0, WAKE_LEVEL, 8'h00, 16);
      begin
        repeat (10) tick();
        chk({15'h0, sdo_oe}, 16'h0001);
      end
    join
    chk(rx, 16'h3C00);
    chk({15'h0, sdo_oe}, 16'h0000);
    frame(1'b0, FAMILY_ID, 8'h00, 16);
    chk(rx, {FAMILY_ID_VAL, 8'h00});
    $display("status test done");
    frame(1'b1, CAN_CTRL, 8'h05, 16);
    chk(rx, 16'h0000);
    frame(1'b0, CAN_CTRL, 8'hFF, 16);
    chk(rx, 16'h0500);
    frame(1'b0, CAN_CTRL, 8'h00, 16);
    chk(rx, 16'h0500);
    chk({13'h0, can}, 16'h0005);
    frame(1'b1, CAN_CTRL, 8'h02, 8);
    frame(1'b0, CAN_CTRL, 8'h00, 16);
    chk(rx, 16'h0500);
    chk({15'h0, err}, 16'h0001);
    frame(1'b1, MODE_CTRL, 8'h08, 16);
    frame(1'b1, HS_CTRL_A, 8'h0F, 16);
    chk({11'h0, aux, hs}, 16'h001F);
    sfault = 4'h1;
    tick();
    sfault = 4'h0;
    repeat (3) tick();
    chk({12'h0, hs}, 16'h000E);
    $display("control test done");
    go_mode(MODE_STOP);
    chk({13'h0, can}, 16'h0005);
    go_mode(MODE_SLEEP);
    frame(1'b1, HS_CTRL_A, 8'h03, 16);
    frame(1'b0, MODE_CTRL, 8'h00, 16);
    chk(rx, 16'h8800);
    frame(1'b0, CAN_CTRL, 8'h00, 16);
    chk(rx, 16'h0100);
    frame(1'b0, HS_CTRL_A, 8'h00, 16);
    chk(rx, 16'h0E00);
    ftrig = 1'b1;
    tick();
    ftrig = 1'b0;
    go_mode(MODE_RESTART);
    chk({11'h0, fail_out, hs}, 16'h0010);
    chk({15'h0, aux}, 16'h0000);
    frame(1'b1, CAN_CTRL, 8'h06, 16);
    go_mode(MODE_NORMAL);
    frame(1'b0, CAN_CTRL, 8'h00, 16);
    chk(rx, 16'h0100);
    chk({15'h0, err}, 16'h0001);
    frame(1'b0, MODE_CTRL, 8'h00, 16);
    chk(rx, 16'h0000);
    $display("mode test done");
    end_sim();
  end
endmodule
`default_nettype wire
